//--- vme_irq_bcast_pkg.sv
`default_nettype none
package vme_irq_bcast_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [11:0] CLOCK_PERIOD_ADDR = 12'h43C;
    localparam logic [11:0] CONTROL_ADDR = 12'h440;
    localparam logic [11:0] PULSE_WIDTH_ADDR = 12'h438;
    localparam logic [23:0] CLOCK_PERIOD_RESET = 24'h0003E8;
    localparam logic [15:0] PULSE_WIDTH_RESET = 16'h0022;
    localparam logic [7:0] ACK_VECTOR_RESET = 8'h0F;
    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    localparam int COUNTER_SRC_POS = 30;
    localparam int EDGE_SRC_POS = 28;
    localparam int LINE1_FN_POS = 26;
    localparam int LINE2_FN_POS = 24;
    localparam int PULSE_TRIGGER_POS = 23;
    localparam int PULSE_STATUS_POS = 22;
    localparam int WITHDRAW_POS = 15;
    localparam int LEVEL_STATUS_POS = 12;
    localparam int UNACK_STATUS_POS = 11;
    localparam int REQUEST_LEVEL_POS = 8;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLOCK_MHZ = 250;
    localparam int TICK_NS = 1020;
    localparam int PULSE_STEP_NS = 30;
    localparam int TICK_CYCLES = TICK_NS * CLOCK_MHZ / 1000;
    localparam int PULSE_STEP_CYCLES = PULSE_STEP_NS * CLOCK_MHZ / 1000;

    typedef enum logic [1:0] {SRC_OFF, SRC_LINE1, SRC_LINE2, SRC_RSVD} source_sel_t;
    typedef enum logic [1:0] {FN_NORMAL, FN_PULSE, FN_PROG_CLOCK, FN_FIXED_CLOCK} line_fn_t;

    typedef struct packed {
        logic [2:0] level;
        logic [7:0] vector;
    } ack_answer_t;
endpackage
`default_nettype wire

//--- vme_interrupter_broadcast_ctl.sv
`default_nettype none
module vme_interrupter_broadcast_ctl (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] pulse_width_field,
    input wire logic line1_in,
    input wire logic line2_in,
    output logic line1_out,
    output logic line2_out,
    output logic irq_request,
    output logic [2:0] irq_level,
    input wire logic iack_done,
    output vme_irq_bcast_pkg::ack_answer_t ack_answer,
    output logic count_event,
    output logic edge_event
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [23:0] period_reg, period_next;
    logic [1:0] cnt_src_reg, cnt_src_next, edge_src_reg, edge_src_next;
    logic [1:0] fn1_reg, fn1_next, fn2_reg, fn2_next;
    logic [7:0] vector_reg, vector_next;
    logic [2:0] level_reg, level_next;
    logic pend_reg, pend_next;
    logic [9:0] tick_cnt_reg, tick_cnt_next;
    logic tick_out_reg, tick_out_next;
    logic [23:0] clk_cnt_reg, clk_cnt_next;
    logic prog_out_reg, prog_out_next;
    logic pulse_reg, pulse_next;
    logic [15:0] pw_cnt_reg, pw_cnt_next;
    logic [2:0] step_reg, step_next;
    logic in1_reg, in2_reg;
    logic aw_reg, aw_next, w_reg, w_next, b_reg, b_next, r_reg, r_next;
    logic [11:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic do_write, tick, prog_evt, wr_ctl, pulse_mode;

    function automatic logic line_pick(input logic [1:0] sel, input logic a, input logic b);
        return (sel == 2'h1) ? a : ((sel == 2'h2) ? b : 1'b0);
    endfunction

    function automatic logic line_drive(input logic [1:0] fn, input logic normal,
                                        input logic pulse, input logic prog,
                                        input logic fixed);
        unique case (vme_irq_bcast_pkg::line_fn_t'(fn))
            vme_irq_bcast_pkg::FN_NORMAL: return normal;
            vme_irq_bcast_pkg::FN_PULSE: return pulse;
            vme_irq_bcast_pkg::FN_PROG_CLOCK: return prog;
            vme_irq_bcast_pkg::FN_FIXED_CLOCK: return fixed;
        endcase
    endfunction

    function automatic logic [31:0] ctl_word(input logic [1:0] cs, input logic [1:0] es,
                                             input logic [1:0] f1, input logic [1:0] f2,
                                             input logic ps, input logic [2:0] lv,
                                             input logic pd, input logic [7:0] vec);
        logic [31:0] w;
        w = 32'h00000000;
        w[vme_irq_bcast_pkg::COUNTER_SRC_POS +: 2] = cs;
        w[vme_irq_bcast_pkg::EDGE_SRC_POS +: 2] = es;
        w[vme_irq_bcast_pkg::LINE1_FN_POS +: 2] = f1;
        w[vme_irq_bcast_pkg::LINE2_FN_POS +: 2] = f2;
        w[vme_irq_bcast_pkg::PULSE_STATUS_POS] = ps;
        w[vme_irq_bcast_pkg::LEVEL_STATUS_POS +: 3] = lv;
        w[vme_irq_bcast_pkg::UNACK_STATUS_POS] = pd;
        w[7:0] = vec;
        return w;
    endfunction

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    assign s_axi_awready = !aw_reg && !b_reg;
    assign s_axi_wready = !w_reg && !b_reg;
    assign s_axi_arready = !r_reg;
    assign do_write = aw_reg && w_reg && !b_reg;
    assign wr_ctl = do_write && awaddr_reg == vme_irq_bcast_pkg::CONTROL_ADDR;
    assign pulse_mode = fn1_reg == 2'h1 || fn2_reg == 2'h1;

    always_comb begin
        aw_next = aw_reg;
        w_next = w_reg;
        b_next = b_reg;
        r_next = r_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bresp_next = bresp_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_next = 1'b1;
            wdata_next = s_axi_wdata;
            // strobes are kept with the data: the master may drop them once w is taken
            wstrb_next = s_axi_wstrb;
        end
        if (do_write) begin
            aw_next = 1'b0;
            w_next = 1'b0;
            b_next = 1'b1;
            bresp_next = (awaddr_reg == vme_irq_bcast_pkg::CONTROL_ADDR
                || awaddr_reg == vme_irq_bcast_pkg::CLOCK_PERIOD_ADDR)
                ? vme_irq_bcast_pkg::AXI_OKAY : vme_irq_bcast_pkg::AXI_SLVERR;
        end
        if (b_reg && s_axi_bready) begin
            b_next = 1'b0;
        end
        if (r_reg && s_axi_rready) begin
            r_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            r_next = 1'b1;
            rresp_next = vme_irq_bcast_pkg::AXI_OKAY;
            unique case (s_axi_araddr)
                vme_irq_bcast_pkg::CLOCK_PERIOD_ADDR: rdata_next = {8'h00, period_reg};
                // trigger, withdraw and request level always read zero
                vme_irq_bcast_pkg::CONTROL_ADDR: rdata_next = ctl_word(cnt_src_reg,
                    edge_src_reg, fn1_reg, fn2_reg, pulse_reg, level_reg, pend_reg,
                    vector_reg);
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = vme_irq_bcast_pkg::AXI_SLVERR;
                end
            endcase
        end
    end

    // ----------------------------------------
    // registers and interrupter
    // ----------------------------------------
    always_comb begin
        period_next = period_reg;
        cnt_src_next = cnt_src_reg;
        edge_src_next = edge_src_reg;
        fn1_next = fn1_reg;
        fn2_next = fn2_reg;
        vector_next = vector_reg;
        level_next = level_reg;
        pend_next = pend_reg;
        if (do_write && awaddr_reg == vme_irq_bcast_pkg::CLOCK_PERIOD_ADDR
            && wdata_reg[23:0] != 24'h000000 && wstrb_reg != 4'h0) begin
            period_next = wdata_reg[23:0];
        end
        if (wr_ctl && wstrb_reg[3]) begin
            cnt_src_next = wdata_reg[vme_irq_bcast_pkg::COUNTER_SRC_POS +: 2];
            edge_src_next = wdata_reg[vme_irq_bcast_pkg::EDGE_SRC_POS +: 2];
            fn1_next = wdata_reg[vme_irq_bcast_pkg::LINE1_FN_POS +: 2];
            fn2_next = wdata_reg[vme_irq_bcast_pkg::LINE2_FN_POS +: 2];
        end
        if (wr_ctl && wstrb_reg[0]) begin
            vector_next = wdata_reg[7:0];
        end
        if (pend_reg && iack_done) begin
            pend_next = 1'b0;
            level_next = 3'h0;
        end
        if (wr_ctl && wstrb_reg[1] && wdata_reg[vme_irq_bcast_pkg::WITHDRAW_POS]) begin
            pend_next = 1'b0;
            level_next = 3'h0;
        end else if (wr_ctl && wstrb_reg[1]
            && wdata_reg[vme_irq_bcast_pkg::REQUEST_LEVEL_POS +: 3] != 3'h0) begin
            // a new request wins over an acknowledge of the old one in the same cycle
            pend_next = 1'b1;
            level_next = wdata_reg[vme_irq_bcast_pkg::REQUEST_LEVEL_POS +: 3];
        end
    end

    // ----------------------------------------
    // broadcast generators
    // ----------------------------------------
    assign tick = tick_cnt_reg == 10'(vme_irq_bcast_pkg::TICK_CYCLES - 1);
    assign prog_evt = tick && clk_cnt_reg >= period_reg - 24'h1;

    always_comb begin
        tick_cnt_next = tick ? 10'h000 : tick_cnt_reg + 10'h001;
        // fixed clock toggles twice per tick so its period is one tick
        tick_out_next = (tick || tick_cnt_reg == 10'(vme_irq_bcast_pkg::TICK_CYCLES / 2 - 1))
            ? !tick_out_reg : tick_out_reg;
        clk_cnt_next = clk_cnt_reg;
        prog_out_next = prog_out_reg;
        if (tick) begin
            clk_cnt_next = clk_cnt_reg + 24'h000001;
            if (prog_evt) begin
                clk_cnt_next = 24'h000000;
                prog_out_next = !prog_out_reg;
            end
        end
        pulse_next = pulse_reg;
        pw_cnt_next = pw_cnt_reg;
        step_next = step_reg;
        if (pulse_reg) begin
            step_next = (step_reg == 3'(vme_irq_bcast_pkg::PULSE_STEP_CYCLES - 1))
                ? 3'h0 : step_reg + 3'h1;
            if (step_reg == 3'(vme_irq_bcast_pkg::PULSE_STEP_CYCLES - 1)) begin
                pw_cnt_next = pw_cnt_reg + 16'h0001;
                if (pw_cnt_reg + 16'h0001 >= pulse_width_field) begin
                    pulse_next = 1'b0;
                    pw_cnt_next = 16'h0000;
                end
            end
        end else if (wr_ctl && wstrb_reg[2] && pulse_mode
            && wdata_reg[vme_irq_bcast_pkg::PULSE_TRIGGER_POS]) begin
            pulse_next = 1'b1;
            pw_cnt_next = 16'h0000;
            step_next = 3'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            b_reg <= 1'b0;
            r_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            rdata_reg <= 32'h00000000;
            bresp_reg <= 2'h0;
            rresp_reg <= 2'h0;
            period_reg <= vme_irq_bcast_pkg::CLOCK_PERIOD_RESET;
            cnt_src_reg <= 2'h0;
            edge_src_reg <= 2'h0;
            fn1_reg <= 2'h0;
            fn2_reg <= 2'h0;
            vector_reg <= vme_irq_bcast_pkg::ACK_VECTOR_RESET;
            level_reg <= 3'h0;
            pend_reg <= 1'b0;
            tick_cnt_reg <= 10'h000;
            tick_out_reg <= 1'b0;
            clk_cnt_reg <= 24'h000000;
            prog_out_reg <= 1'b0;
            pulse_reg <= 1'b0;
            pw_cnt_reg <= 16'h0000;
            step_reg <= 3'h0;
            in1_reg <= 1'b0;
            in2_reg <= 1'b0;
        end else begin
            aw_reg <= aw_next;
            w_reg <= w_next;
            b_reg <= b_next;
            r_reg <= r_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            rdata_reg <= rdata_next;
            bresp_reg <= bresp_next;
            rresp_reg <= rresp_next;
            period_reg <= period_next;
            cnt_src_reg <= cnt_src_next;
            edge_src_reg <= edge_src_next;
            fn1_reg <= fn1_next;
            fn2_reg <= fn2_next;
            vector_reg <= vector_next;
            level_reg <= level_next;
            pend_reg <= pend_next;
            tick_cnt_reg <= tick_cnt_next;
            tick_out_reg <= tick_out_next;
            clk_cnt_reg <= clk_cnt_next;
            prog_out_reg <= prog_out_next;
            pulse_reg <= pulse_next;
            pw_cnt_reg <= pw_cnt_next;
            step_reg <= step_next;
            in1_reg <= line1_in;
            in2_reg <= line2_in;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign s_axi_bvalid = b_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = r_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign irq_request = pend_reg;
    assign irq_level = level_reg;
    assign ack_answer = '{level: level_reg, vector: vector_reg};
    // normal mode drives the line high when a request at that level is pending
    assign line1_out = line_drive(fn1_reg, pend_reg && level_reg == 3'h1, pulse_reg,
        prog_out_reg, tick_out_reg);
    assign line2_out = line_drive(fn2_reg, pend_reg && level_reg == 3'h2, pulse_reg,
        prog_out_reg, tick_out_reg);
    // rising edges on the chosen input; an unselected line yields nothing
    assign count_event = line_pick(cnt_src_reg, line1_in && !in1_reg,
        line2_in && !in2_reg);
    assign edge_event = line_pick(edge_src_reg, line1_in && !in1_reg,
        line2_in && !in2_reg);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence trig_seq;
        wr_ctl && wstrb_reg[2] && pulse_mode && wdata_reg[23] && !pulse_reg;
    endsequence
    AST_PULSE_START: assert property (@(posedge mclk) disable iff (sys_rst)
        trig_seq |=> pulse_reg) else $error("pulse did not start");
    AST_WITHDRAW: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_ctl && wstrb_reg[1] && wdata_reg[15] |=> !pend_reg && level_reg == 3'h0)
        else $error("withdraw failed");
    AST_REQUEST: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_ctl && wstrb_reg[1] && !wdata_reg[15] && wdata_reg[10:8] != 3'h0
        |=> pend_reg && level_reg == $past(wdata_reg[10:8])) else $error("no request");
    AST_IACK: assert property (@(posedge mclk) disable iff (sys_rst)
        pend_reg && iack_done && !(wr_ctl && wstrb_reg[1]) |=> !pend_reg)
        else $error("ack did not clear");
    AST_ZERO_PERIOD: assert property (@(posedge mclk) disable iff (sys_rst)
        do_write && awaddr_reg == 12'h43C && wdata_reg[23:0] == 24'h0 |=> $stable(period_reg))
        else $error("zero period stored");
    AST_PROG_CLOCK: assert property (@(posedge mclk) disable iff (sys_rst)
        prog_evt |=> clk_cnt_reg == 24'h0 && prog_out_reg != $past(prog_out_reg))
        else $error("clock event missing");
    AST_TICK: assert property (@(posedge mclk) disable iff (sys_rst)
        tick |=> !tick [*8]) else $error("tick too often");
    AST_NO_COUNT_OFF: assert property (@(posedge mclk) disable iff (sys_rst)
        cnt_src_reg == 2'h0 |-> !count_event) else $error("count while off");
endmodule
`default_nettype wire

//--- vme_iack_handler.sv
`default_nettype none
module vme_iack_handler (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic [7:0] delay,
    input wire logic irq_request,
    input wire logic [2:0] irq_level,
    input wire vme_irq_bcast_pkg::ack_answer_t ack_answer,
    output logic iack_done,
    output logic [7:0] vector_seen,
    output logic [2:0] level_seen,
    output logic [7:0] ack_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // acknowledge cycle after a programmable wait
    // ----------------------------------------
    logic [7:0] wait_reg;

    // the wait restarts after each ack so a stale request cannot be taken twice
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            iack_done <= 1'b0;
            wait_reg <= 8'h00;
            vector_seen <= 8'h00;
            level_seen <= 3'h0;
            ack_count <= 8'h00;
        end else if (iack_done) begin
            iack_done <= 1'b0;
            wait_reg <= 8'h00;
        end else if (enable && irq_request) begin
            if (wait_reg == delay) begin
                iack_done <= 1'b1;
                vector_seen <= ack_answer.vector;
                level_seen <= irq_level;
                ack_count <= ack_count + 8'h01;
            end else begin
                wait_reg <= wait_reg + 8'h01;
            end
        end else begin
            wait_reg <= 8'h00;
        end
    end
endmodule
`default_nettype wire

//--- vme_interrupter_broadcast_ctl_tb_top.sv
`default_nettype none
module vme_interrupter_broadcast_ctl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] PER = vme_irq_bcast_pkg::CLOCK_PERIOD_ADDR;
    localparam logic [11:0] CTL = vme_irq_bcast_pkg::CONTROL_ADDR;
    localparam int T = vme_irq_bcast_pkg::TICK_CYCLES;
    logic mclk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, line1_in, line2_in, line1_out, line2_out;
    logic irq_request, iack_done, count_event, edge_event, h_en;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r, b;
    logic [2:0] irq_level, level_seen;
    logic [15:0] width;
    logic [7:0] vector_seen, ack_count;
    vme_irq_bcast_pkg::ack_answer_t ack_answer;
    int fails, checked, n;

    vme_interrupter_broadcast_ctl dut (.mclk(mclk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pulse_width_field(width),
        .line1_in(line1_in), .line2_in(line2_in), .line1_out(line1_out),
        .line2_out(line2_out), .irq_request(irq_request), .irq_level(irq_level),
        .iack_done(iack_done), .ack_answer(ack_answer), .count_event(count_event),
        .edge_event(edge_event));
    vme_iack_handler handler (.mclk(mclk), .sys_rst(sys_rst), .enable(h_en),
        .delay(8'h1E), .irq_request(irq_request), .irq_level(irq_level),
        .ack_answer(ack_answer), .iack_done(iack_done), .vector_seen(vector_seen),
        .level_seen(level_seen), .ack_count(ack_count));
    // ----------------------------------------
    // bus tasks and checking
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // entered one edge late so bready or rready never changes twice in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
        logic aw_done, w_done;
        @(posedge mclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        while (!(aw_done && w_done)) begin
            @(posedge mclk);
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge mclk);
        b = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] e);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge mclk);
        v = rdata;
        e = rresp;
        rready <= 1'b0;
    endtask
    // cycles between two toggles of the chosen output line
    task automatic gap(input bit second, output int c);
        logic v;
        v = second ? line2_out : line1_out;
        while ((second ? line2_out : line1_out) === v) @(posedge mclk);
        v = second ? line2_out : line1_out;
        c = 0;
        while ((second ? line2_out : line1_out) === v) begin
            @(posedge mclk);
            c++;
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // clock, watchdog and tests
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        repeat (40000) @(posedge mclk);
        fails++;
        stop_test();
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, line1_in, line2_in, h_en} = 8'h00;
        {awaddr, araddr, wdata, wstrb} = 60'h0;
        width = 16'h0004;
        sys_rst = 1'b1;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(PER, d, r); chk(d, 32'h000003E8);
        rd(CTL, d, r); chk(d, 32'h0000000F);
        wr(PER, 32'h0, 4'hF); chk(32'(b), 32'(vme_irq_bcast_pkg::AXI_OKAY));
        rd(PER, d, r); chk(d, 32'h000003E8);
        rd(12'h400, d, r); chk(32'(r), 32'(vme_irq_bcast_pkg::AXI_SLVERR));
        wr(12'h400, 32'h1, 4'hF); chk(32'(b), 32'(vme_irq_bcast_pkg::AXI_SLVERR));
        // only periods above one are ever programmed
        wr(PER, 32'h00000002, 4'hF); rd(PER, d, r); chk(d, 32'h00000002);
        wr(CTL, 32'h0B000000, 4'h8);
        gap(0, n); chk(32'(n >= 2 * T - 2 && n <= 3 * T + 2), 32'h1);
        gap(1, n); chk(32'(n >= T / 2 - 2 && n <= 2 * T + 2), 32'h1);
        wr(PER, 32'h00000003, 4'hF); wr(CTL, 32'h0E000000, 4'h8);
        gap(1, n); chk(32'(n >= 3 * T - 2 && n <= 4 * T + 2), 32'h1);
        gap(0, n); chk(32'(n >= T / 2 - 2 && n <= 2 * T + 2), 32'h1);
        wr(CTL, 32'h04000000, 4'h8);
        for (int i = 0; i < 2; i++) begin
            width <= i ? 16'h0010 : 16'h0004;
            wr(CTL, 32'h00800000, 4'h4);
            rd(CTL, d, r); chk(d, 32'h0440000F); chk(32'(line1_out), 32'h1);
            repeat (40) @(posedge mclk);
            rd(CTL, d, r); chk(32'(d[22]), 32'(i));
            repeat (120) @(posedge mclk);
            chk(32'(line1_out), 32'h0);
        end
        wr(CTL, 32'h00000000, 4'h8);
        wr(CTL, 32'h000002A5, 4'h3); rd(CTL, d, r); chk(d, 32'h000028A5);
        chk(32'(line2_out), 32'h1);
        wr(CTL, 32'h000000A5, 4'h3); rd(CTL, d, r); chk(d, 32'h000028A5);
        // nobody will acknowledge, so the request is pulled back
        wr(CTL, 32'h00008000, 4'h2); rd(CTL, d, r); chk(d, 32'h000000A5);
        chk(32'(irq_request), 32'h0); chk(32'(line2_out), 32'h0);
        h_en <= 1'b1;
        wr(CTL, 32'h0000013C, 4'h3); rd(CTL, d, r); chk(d, 32'h0000183C);
        chk(32'(line1_out), 32'h1);
        repeat (50) @(posedge mclk);
        chk({ack_count, vector_seen, 13'h0, level_seen}, 32'h013C0001);
        rd(CTL, d, r); chk(d, 32'h0000003C);
        for (int s = 0; s < 3; s++) begin
            wr(CTL, {2'(s), 2'((s + 1) % 3), 28'h0}, 4'h8);
            for (int l = 1; l < 3; l++) begin
                @(posedge mclk);
                if (l == 1) line1_in <= 1'b1;
                else line2_in <= 1'b1;
                @(negedge mclk);
                chk(32'(count_event), 32'(s == l));
                chk(32'(edge_event), 32'((s + 1) % 3 == l));
                @(posedge mclk);
                line1_in <= 1'b0;
                line2_in <= 1'b0;
            end
        end
        wr(PER, 32'h00000005, 4'hF);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(PER, d, r); chk(d, 32'h000003E8);
        rd(CTL, d, r); chk(d, 32'h0000000F);
        stop_test();
    end
endmodule
`default_nettype wire
